// [core/ulprm_register_map.v]
// Operation
// - plain write replaces the whole byte
// - set address ORs byte into register
// - clear address clears masked register bits
// - read-only registers ignore every write
// - rising enable at 0Dh, set 0Eh, clear 0Fh
// - falling enable at 10h, set 11h, clear 12h
// - interrupt status read-only at 13h
// - interrupt latch read-only at 14h
// - maker code bytes at 00h and 01h
// - part code bytes at 02h and 03h
// - 2Fh is write-only extended access gate
// - extended 00h-3Fh mirror the immediate set
`timescale 1ns/100ps
`include "ulprm_defines.vh"

module ulprm_register_map
#(
  parameter [7:0] MAKER_CODE_LOW  = 8'h5a, // arbitrary value
  parameter [7:0] MAKER_CODE_HIGH = 8'h3c, // arbitrary value
  parameter [7:0] PART_CODE_LOW   = 8'h69, // arbitrary value
  parameter [7:0] PART_CODE_HIGH  = 8'h96  // arbitrary value
)
(
  input  wire       ref_clk,            // ulpi interface clock
  input  wire       reset,              // synchronous reset, active high
  input  wire       reg_wr,             // one-cycle write request
  input  wire       reg_rd,             // one-cycle read request
  input  wire       reg_extended,       // address is from the extended set
  input  wire [7:0] reg_addr,           // register address
  input  wire [7:0] reg_wdata,          // write byte
  output reg  [7:0] reg_rdata,          // read byte, valid with reg_rvalid
  output reg        reg_rvalid,         // one-cycle pulse, read data ready
  output reg        ext_gate_wr,        // pulse, write seen at 2Fh
  output reg  [7:0] ext_gate_data,      // byte written at 2Fh
  input  wire [7:0] irq_status_now,     // live interrupt sources
  input  wire [7:0] irq_latched,        // latched interrupt events
  input  wire [7:0] line_debug_view,    // debug line view
  input  wire [7:0] maker_specific_rd,  // read data of 30h-3Ch block
  output reg        maker_specific_wr,  // pulse, write into 30h-3Ch
  output wire [7:0] transceiver_function_ctrl, // function control byte
  output wire [7:0] link_interface_ctrl,       // interface control byte
  output wire [7:0] dual_role_ctrl,            // dual-role control byte
  output wire [7:0] irq_enable_rise,           // rising-edge enables
  output wire [7:0] irq_enable_fall,           // falling-edge enables
  output wire [7:0] scratch_byte,              // scratch byte
  output wire [7:0] power_ctrl                 // power control byte
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // extended addresses above the mirror range are reserved and dropped
  wire       in_range;   // access lands inside the decoded space
  wire [7:0] addr_full;  // six-bit address, zero extended for compares
  wire       wr_ok;      // write that may reach a register
  wire       maker_hit;  // address inside the maker-specific block

  assign in_range  = ~reg_extended | (reg_addr <= `ULPRM_ADDR_MIRROR_LAST);
  assign addr_full = {2'b00, reg_addr[5:0]};
  assign wr_ok     = reg_wr & in_range;
  assign maker_hit = (addr_full >= `ULPRM_ADDR_MAKER_FIRST)
                     & (addr_full < `ULPRM_ADDR_POWER_CTRL);

  // set and clear aliases sit one and two above each base address
  localparam [7:0] FUNC_SET      = `ULPRM_ADDR_FUNC_CTRL  + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] FUNC_CLEAR    = `ULPRM_ADDR_FUNC_CTRL  + {6'h00, `ULPRM_ALIAS_CLEAR};
  localparam [7:0] IFC_SET       = `ULPRM_ADDR_IFC_CTRL   + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] IFC_CLEAR     = `ULPRM_ADDR_IFC_CTRL   + {6'h00, `ULPRM_ALIAS_CLEAR};
  localparam [7:0] DUAL_SET      = `ULPRM_ADDR_DUAL_CTRL  + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] DUAL_CLEAR    = `ULPRM_ADDR_DUAL_CTRL  + {6'h00, `ULPRM_ALIAS_CLEAR};
  localparam [7:0] RISE_SET      = `ULPRM_ADDR_IRQ_RISE   + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] RISE_CLEAR    = `ULPRM_ADDR_IRQ_RISE   + {6'h00, `ULPRM_ALIAS_CLEAR};
  localparam [7:0] FALL_SET      = `ULPRM_ADDR_IRQ_FALL   + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] FALL_CLEAR    = `ULPRM_ADDR_IRQ_FALL   + {6'h00, `ULPRM_ALIAS_CLEAR};
  localparam [7:0] SCRATCH_SET   = `ULPRM_ADDR_SCRATCH    + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] SCRATCH_CLEAR = `ULPRM_ADDR_SCRATCH    + {6'h00, `ULPRM_ALIAS_CLEAR};
  localparam [7:0] POWER_SET     = `ULPRM_ADDR_POWER_CTRL + {6'h00, `ULPRM_ALIAS_SET};
  localparam [7:0] POWER_CLEAR   = `ULPRM_ADDR_POWER_CTRL + {6'h00, `ULPRM_ALIAS_CLEAR};

  // ----------------------------------------------------------------
  // read/write/set/clear control registers
  // ----------------------------------------------------------------

  // function control; one instance per byte keeps each reset value a plain constant
  wire func_wr_plain;  // plain write at the base
  wire func_wr_set;    // bit-set alias
  wire func_wr_clear;  // bit-clear alias

  assign func_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_FUNC_CTRL);
  assign func_wr_set   = wr_ok & (addr_full == FUNC_SET);
  assign func_wr_clear = wr_ok & (addr_full == FUNC_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_FUNC_CTRL)
  )
  u_func_ctrl
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (func_wr_plain),
    .wr_set   (func_wr_set),
    .wr_clear (func_wr_clear),
    .wr_data  (reg_wdata),
    .value    (transceiver_function_ctrl)
  );

  // interface control
  wire ifc_wr_plain;   // plain write at the base
  wire ifc_wr_set;     // bit-set alias
  wire ifc_wr_clear;   // bit-clear alias

  assign ifc_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_IFC_CTRL);
  assign ifc_wr_set   = wr_ok & (addr_full == IFC_SET);
  assign ifc_wr_clear = wr_ok & (addr_full == IFC_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_IFC_CTRL)
  )
  u_ifc_ctrl
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (ifc_wr_plain),
    .wr_set   (ifc_wr_set),
    .wr_clear (ifc_wr_clear),
    .wr_data  (reg_wdata),
    .value    (link_interface_ctrl)
  );

  // dual-role control
  wire dual_wr_plain;  // plain write at the base
  wire dual_wr_set;    // bit-set alias
  wire dual_wr_clear;  // bit-clear alias

  assign dual_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_DUAL_CTRL);
  assign dual_wr_set   = wr_ok & (addr_full == DUAL_SET);
  assign dual_wr_clear = wr_ok & (addr_full == DUAL_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_DUAL_CTRL)
  )
  u_dual_ctrl
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (dual_wr_plain),
    .wr_set   (dual_wr_set),
    .wr_clear (dual_wr_clear),
    .wr_data  (reg_wdata),
    .value    (dual_role_ctrl)
  );

  // rising-edge interrupt enables
  wire rise_wr_plain;  // plain write at the base
  wire rise_wr_set;    // bit-set alias
  wire rise_wr_clear;  // bit-clear alias

  assign rise_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_IRQ_RISE);
  assign rise_wr_set   = wr_ok & (addr_full == RISE_SET);
  assign rise_wr_clear = wr_ok & (addr_full == RISE_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_IRQ_RISE)
  )
  u_irq_rise
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (rise_wr_plain),
    .wr_set   (rise_wr_set),
    .wr_clear (rise_wr_clear),
    .wr_data  (reg_wdata),
    .value    (irq_enable_rise)
  );

  // falling-edge interrupt enables
  wire fall_wr_plain;  // plain write at the base
  wire fall_wr_set;    // bit-set alias
  wire fall_wr_clear;  // bit-clear alias

  assign fall_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_IRQ_FALL);
  assign fall_wr_set   = wr_ok & (addr_full == FALL_SET);
  assign fall_wr_clear = wr_ok & (addr_full == FALL_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_IRQ_FALL)
  )
  u_irq_fall
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (fall_wr_plain),
    .wr_set   (fall_wr_set),
    .wr_clear (fall_wr_clear),
    .wr_data  (reg_wdata),
    .value    (irq_enable_fall)
  );

  // scratch byte, free for the link to test the bus
  wire scratch_wr_plain; // plain write at the base
  wire scratch_wr_set;   // bit-set alias
  wire scratch_wr_clear; // bit-clear alias

  assign scratch_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_SCRATCH);
  assign scratch_wr_set   = wr_ok & (addr_full == SCRATCH_SET);
  assign scratch_wr_clear = wr_ok & (addr_full == SCRATCH_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_SCRATCH)
  )
  u_scratch
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (scratch_wr_plain),
    .wr_set   (scratch_wr_set),
    .wr_clear (scratch_wr_clear),
    .wr_data  (reg_wdata),
    .value    (scratch_byte)
  );

  // power control, the last group of the mirrored range
  wire power_wr_plain; // plain write at the base
  wire power_wr_set;   // bit-set alias
  wire power_wr_clear; // bit-clear alias

  assign power_wr_plain = wr_ok & (addr_full == `ULPRM_ADDR_POWER_CTRL);
  assign power_wr_set   = wr_ok & (addr_full == POWER_SET);
  assign power_wr_clear = wr_ok & (addr_full == POWER_CLEAR);

  ulprm_sc_reg
  #(
    .RESET_VALUE (`ULPRM_RST_POWER_CTRL)
  )
  u_power_ctrl
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_plain (power_wr_plain),
    .wr_set   (power_wr_set),
    .wr_clear (power_wr_clear),
    .wr_data  (reg_wdata),
    .value    (power_ctrl)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------

  // read-only and reserved addresses get no write path at all
  reg [7:0] next_rdata;

  always @*
  begin
    next_rdata = `ULPRM_READ_ZERO;
    case (addr_full)
      `ULPRM_ADDR_MAKER_LOW:  next_rdata = MAKER_CODE_LOW;
      `ULPRM_ADDR_MAKER_HIGH: next_rdata = MAKER_CODE_HIGH;
      `ULPRM_ADDR_PART_LOW:   next_rdata = PART_CODE_LOW;
      `ULPRM_ADDR_PART_HIGH:  next_rdata = PART_CODE_HIGH;
      `ULPRM_ADDR_FUNC_CTRL,
      FUNC_SET,
      FUNC_CLEAR:             next_rdata = transceiver_function_ctrl;
      `ULPRM_ADDR_IFC_CTRL,
      IFC_SET,
      IFC_CLEAR:              next_rdata = link_interface_ctrl;
      `ULPRM_ADDR_DUAL_CTRL,
      DUAL_SET,
      DUAL_CLEAR:             next_rdata = dual_role_ctrl;
      `ULPRM_ADDR_IRQ_RISE,
      RISE_SET,
      RISE_CLEAR:             next_rdata = irq_enable_rise;
      `ULPRM_ADDR_IRQ_FALL,
      FALL_SET,
      FALL_CLEAR:             next_rdata = irq_enable_fall;
      `ULPRM_ADDR_SCRATCH,
      SCRATCH_SET,
      SCRATCH_CLEAR:          next_rdata = scratch_byte;
      `ULPRM_ADDR_POWER_CTRL,
      POWER_SET,
      POWER_CLEAR:            next_rdata = power_ctrl;
      `ULPRM_ADDR_IRQ_STATUS: next_rdata = irq_status_now;
      `ULPRM_ADDR_IRQ_LATCH:  next_rdata = irq_latched;
      `ULPRM_ADDR_DEBUG:      next_rdata = line_debug_view;
      `ULPRM_ADDR_EXT_GATE:   next_rdata = `ULPRM_READ_ZERO;
      default:
      begin
        if (maker_hit)
          next_rdata = maker_specific_rd;
        else
          next_rdata = `ULPRM_READ_ZERO;
      end
    endcase
    if (!in_range)
      next_rdata = `ULPRM_READ_ZERO;
  end

  // read data is registered; one cycle after the request
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // extended gate and maker-specific writes
  // ----------------------------------------------------------------

  // a write to 2Fh is handed to the link side to open the extended set
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      ext_gate_wr       <= 1'b0;
      ext_gate_data     <= 8'h00;
      maker_specific_wr <= 1'b0;
    end
    else
    begin
      ext_gate_wr       <= wr_ok & (addr_full == `ULPRM_ADDR_EXT_GATE);
      maker_specific_wr <= wr_ok & maker_hit;
      if (wr_ok & (addr_full == `ULPRM_ADDR_EXT_GATE))
        ext_gate_data <= reg_wdata;
    end
  end

endmodule // ulprm_register_map

// [core/ulprm_defines.vh]
`ifndef ULPRM_DEFINES_VH
`define ULPRM_DEFINES_VH
// immediate register addresses
`define ULPRM_ADDR_MAKER_LOW      8'h00
`define ULPRM_ADDR_MAKER_HIGH     8'h01
`define ULPRM_ADDR_PART_LOW       8'h02
`define ULPRM_ADDR_PART_HIGH      8'h03
`define ULPRM_ADDR_FUNC_CTRL      8'h04
`define ULPRM_ADDR_IFC_CTRL       8'h07
`define ULPRM_ADDR_DUAL_CTRL      8'h0a
`define ULPRM_ADDR_IRQ_RISE       8'h0d
`define ULPRM_ADDR_IRQ_FALL       8'h10
`define ULPRM_ADDR_IRQ_STATUS     8'h13
`define ULPRM_ADDR_IRQ_LATCH      8'h14
`define ULPRM_ADDR_DEBUG          8'h15
`define ULPRM_ADDR_SCRATCH        8'h16
// first address of the maker-specific block; it ends below power control
`define ULPRM_ADDR_MAKER_FIRST    8'h30
`define ULPRM_ADDR_EXT_GATE       8'h2f
`define ULPRM_ADDR_POWER_CTRL     8'h3d
// last address that mirrors the immediate set
`define ULPRM_ADDR_MIRROR_LAST    8'h3f
// alias offsets within a three-address group
`define ULPRM_ALIAS_SET           2'h1
`define ULPRM_ALIAS_CLEAR         2'h2
// reset values of the control registers
`define ULPRM_RST_FUNC_CTRL       8'h41
`define ULPRM_RST_IFC_CTRL        8'h00
`define ULPRM_RST_DUAL_CTRL       8'h00
`define ULPRM_RST_IRQ_RISE        8'h00
`define ULPRM_RST_IRQ_FALL        8'h00
`define ULPRM_RST_SCRATCH         8'h00
`define ULPRM_RST_POWER_CTRL      8'h00
// read value of reserved and write-only addresses
`define ULPRM_READ_ZERO           8'h00
`endif

// [core/ulprm_sc_reg.v]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// one control byte with write, set and clear aliases
// ----------------------------------------------------------------
module ulprm_sc_reg
#(
  parameter [7:0] RESET_VALUE = 8'h00
)
(
  input  wire       ref_clk,  // interface clock
  input  wire       reset,    // synchronous reset, active high
  input  wire       wr_plain, // plain write strobe
  input  wire       wr_set,   // bit-set strobe
  input  wire       wr_clear, // bit-clear strobe
  input  wire [7:0] wr_data,  // byte from the link
  output reg  [7:0] value     // stored byte
);

  // at most one strobe is active, since the strobes come from one address
  always @(posedge ref_clk)
  begin
    if (reset)
      value <= RESET_VALUE;
    else if (wr_plain)
      value <= wr_data;
    else if (wr_set)
      value <= value | wr_data;
    else if (wr_clear)
      value <= value & ~wr_data;
  end

endmodule // ulprm_sc_reg

// [verif/ulprm_register_map_checker.sv]
`timescale 1ns/100ps
// ----------------------------------------
// register map checker
// ----------------------------------------
module ulprm_register_map_checker
(
  input wire       ref_clk,         // interface clock
  input wire       reset,           // sync reset
  input wire       reg_wr,          // write request
  input wire       reg_rd,          // read request
  input wire [7:0] reg_addr,        // address
  input wire [7:0] reg_wdata,       // write byte
  input wire [7:0] reg_rdata,       // read byte
  input wire       reg_rvalid,      // read strobe
  input wire       ext_gate_wr,     // gate pulse
  input wire [7:0] irq_status_now,  // live sources
  input wire [7:0] irq_latched,     // latched events
  input wire [7:0] irq_enable_rise, // rising enables
  input wire [7:0] irq_enable_fall, // falling enables
  input wire [7:0] scratch_byte     // scratch byte
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // full-byte address match, so the extended mirror is checked as well
  plain_write_a: assert property (reg_wr && reg_addr == 8'h16
    |=> scratch_byte == $past(reg_wdata)) else $error("plain write lost");
  set_bits_a: assert property (reg_wr && reg_addr == 8'h17
    |=> scratch_byte == ($past(scratch_byte) | $past(reg_wdata))) else $error("set wrong");
  clear_bits_a: assert property (reg_wr && reg_addr == 8'h18
    |=> scratch_byte == ($past(scratch_byte) & ~$past(reg_wdata))) else $error("clear wrong");
  rise_set_a: assert property (reg_wr && reg_addr == 8'h0e
    |=> irq_enable_rise == ($past(irq_enable_rise) | $past(reg_wdata))) else $error("rise set");
  fall_clear_a: assert property (reg_wr && reg_addr == 8'h12
    |=> irq_enable_fall == ($past(irq_enable_fall) & ~$past(reg_wdata))) else $error("fall clr");
  status_read_a: assert property (reg_rd && reg_addr == 8'h13
    |=> reg_rvalid && reg_rdata == $past(irq_status_now)) else $error("status read");
  latch_read_a: assert property (reg_rd && reg_addr == 8'h14
    |=> reg_rvalid && reg_rdata == $past(irq_latched)) else $error("latch read");
  gate_pulse_a: assert property (reg_wr && reg_addr == 8'h2f
    |=> ext_gate_wr ##1 (!ext_gate_wr || $past(reg_wr && reg_addr[5:0] == 6'h2f)))
    else $error("gate pulse");
  gate_source_a: assert property (ext_gate_wr
    |-> $past(reg_wr && reg_addr[5:0] == 6'h2f)) else $error("gate pulse without write");
  reserved_read_a: assert property (reg_rd && reg_addr inside {[8'h19:8'h2e]}
    |=> reg_rvalid && reg_rdata == 8'h00) else $error("reserved read");
endmodule // ulprm_register_map_checker

bind ulprm_register_map ulprm_register_map_checker u_chk
(
  .ref_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
  .ext_gate_wr, .irq_status_now, .irq_latched, .irq_enable_rise, .irq_enable_fall,
  .scratch_byte
);

// [verif/ulprm_link_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// link side issuing register accesses
// ----------------------------------------
module ulprm_link_model
(
  input  wire       ref_clk,      // interface clock
  output reg        reg_wr,       // write request
  output reg        reg_rd,       // read request
  output reg        reg_extended, // extended address
  output reg  [7:0] reg_addr,     // address
  output reg  [7:0] reg_wdata,    // write byte
  input  wire [7:0] reg_rdata,    // read byte
  input  wire       reg_rvalid    // read strobe
);
  initial {reg_wr, reg_rd, reg_extended, reg_addr, reg_wdata} = 19'h0;
  // idle bus shows inverted values so a stale copy cannot pass
  // reserved addresses are touched only when a test asks
  task wr(input [7:0] a, input [7:0] d, input x);
    begin
      @(negedge ref_clk);
      {reg_wr, reg_extended, reg_addr, reg_wdata} = {1'b1, x, a, d};
      @(negedge ref_clk);
      reg_wr = 1'b0;
      {reg_addr, reg_wdata} = ~{a, d};
    end
  endtask
  // answer lands one cycle after the request edge
  task rd(input [7:0] a, input x, output [7:0] q, output v);
    begin
      @(negedge ref_clk);
      {reg_rd, reg_extended, reg_addr} = {1'b1, x, a};
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      q = reg_rdata;
      v = reg_rvalid;
    end
  endtask
endmodule // ulprm_link_model

// [verif/ulprm_register_map_tb_top.sv]
`timescale 1ns/100ps
module ulprm_register_map_tb_top;
  localparam [31:0] IDS   = 32'h21436587;       // arbitrary id values
  localparam [55:0] BASES = 56'h04070a0d10163d;
  localparam [55:0] RSTS  = 56'h41000000000000;
  reg        ref_clk = 1'b0;
  reg        reset   = 1'b1;
  reg  [7:0] irq_status_now = 8'hc3, irq_latched = 8'h3c;
  reg  [7:0] line_debug_view = 8'h99, maker_specific_rd = 8'h5e;
  wire       reg_wr, reg_rd, reg_extended, reg_rvalid, ext_gate_wr, maker_specific_wr;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, ext_gate_data, scratch_byte, power_ctrl;
  wire [7:0] transceiver_function_ctrl, link_interface_ctrl, dual_role_ctrl;
  wire [7:0] irq_enable_rise, irq_enable_fall;
  integer    n_fail = 0, total_checks = 0, cycles = 0, i;
  reg  [7:0] q, b;
  reg        v;
  ulprm_link_model link (.ref_clk, .reg_wr, .reg_rd, .reg_extended, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid);
  ulprm_register_map #(.MAKER_CODE_LOW(IDS[31:24]), .MAKER_CODE_HIGH(IDS[23:16]),
    .PART_CODE_LOW(IDS[15:8]), .PART_CODE_HIGH(IDS[7:0])) dut (.ref_clk, .reset,
    .reg_wr, .reg_rd, .reg_extended, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .ext_gate_wr, .ext_gate_data, .irq_status_now, .irq_latched, .line_debug_view,
    .maker_specific_rd, .maker_specific_wr, .transceiver_function_ctrl,
    .link_interface_ctrl, .dual_role_ctrl, .irq_enable_rise, .irq_enable_fall,
    .scratch_byte, .power_ctrl);
  always #12.5 ref_clk = ~ref_clk;
  // hang guard, far beyond the fewer than two hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 4000)
    begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  task chk(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rchk(input [7:0] a, input x, input [7:0] exp);
    begin
      link.rd(a, x, q, v);
      chk("rvalid", {7'h0, v}, 8'h01);
      chk("rdata", q, exp);
    end
  endtask
  task summarize;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    for (i = 0; i < 7; i = i + 1)
    begin
      b = BASES[8*(6-i)+:8];
      rchk(b, 1'b0, RSTS[8*(6-i)+:8]);
      link.wr(b, 8'ha5, 1'b0);
      rchk(b, 1'b0, 8'ha5);
      link.wr(b + 8'h01, 8'h0a, 1'b0);
      rchk(b, 1'b0, 8'haf);
      link.wr(b + 8'h02, 8'h21, 1'b0);
      rchk(b + 8'h02, 1'b1, 8'h8e);
    end
    link.wr(8'h17, 8'h40, 1'b1);
    rchk(8'h16, 1'b0, 8'hce);
    for (i = 0; i < 4; i = i + 1)
    begin
      link.wr(i[7:0], 8'hff, 1'b0);
      rchk(i[7:0], 1'b0, IDS[8*(3-i)+:8]);
    end
    link.wr(8'h13, 8'h00, 1'b0);
    link.wr(8'h14, 8'h00, 1'b0);
    rchk(8'h13, 1'b0, 8'hc3);
    rchk(8'h14, 1'b1, 8'h3c);
    rchk(8'h15, 1'b0, 8'h99);
    rchk(8'h30, 1'b0, 8'h5e);
    link.wr(8'h2f, 8'h77, 1'b0);
    chk("gate_wr", {7'h0, ext_gate_wr}, 8'h01);
    chk("gatedata", ext_gate_data, 8'h77);
    rchk(8'h2f, 1'b0, 8'h00);
    link.wr(8'h19, 8'hff, 1'b0);
    link.wr(8'h2e, 8'hff, 1'b0);
    link.wr(8'h40, 8'hff, 1'b1);
    link.wr(8'hff, 8'hff, 1'b1);
    rchk(8'h2e, 1'b0, 8'h00);
    rchk(8'h40, 1'b1, 8'h00);
    chk("scratch", scratch_byte, 8'hce);
    chk("power", power_ctrl, 8'h8e);
    chk("func", transceiver_function_ctrl, 8'h8e);
    chk("ifc", link_interface_ctrl, 8'h8e);
    chk("dual", dual_role_ctrl, 8'h8e);
    chk("rise", irq_enable_rise, 8'h8e);
    chk("fall", irq_enable_fall, 8'h8e);
    // an extended address past the mirror must not reach the gate
    link.wr(8'h6f, 8'h55, 1'b1);
    chk("gate_off", {7'h0, ext_gate_wr}, 8'h00);
    chk("gatedata", ext_gate_data, 8'h77);
    link.wr(8'h31, 8'h12, 1'b1);
    chk("maker_wr", {7'h0, maker_specific_wr}, 8'h01);
    // second reset in mid-run brings every byte back to its reset value
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    rchk(8'h04, 1'b0, RSTS[55:48]);
    chk("ifc", link_interface_ctrl, 8'h00);
    chk("scratch", scratch_byte, 8'h00);
    summarize;
  end
endmodule // ulprm_register_map_tb_top
